// *** rtl/fram_array.sv ***
// byte array with registered read port
`timescale 1ns/1ps
module fram_array #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 8
) (
    input  wire logic              clock,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data
);
    // storage, nonvolatile in the real part so no reset
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // write and registered read share one clock
    always_ff @(posedge clock) begin
        if (we) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // fram_array

// *** rtl/spi_fram_pkg.sv ***
// types shared by the serial memory slave port
package spi_fram_pkg;
    // byte-level protocol phase, one-hot
    typedef enum logic [8:0] {
        ST_CMD    = 9'h001,
        ST_ADDR   = 9'h002,
        ST_DUMMY  = 9'h004,
        ST_RDATA  = 9'h008,
        ST_WDATA  = 9'h010,
        ST_SREAD  = 9'h020,
        ST_SWRITE = 9'h040,
        ST_IDRD   = 9'h080,
        ST_IGNORE = 9'h100
    } phase_t;
endpackage

// *** rtl/spi_fram_regs.svh ***
// constants of the serial memory slave port: opcodes, status layout, counts
// Function
// - sample input on rise, drive output on fall
// - clock below half the system clock rate, state kept when clock stops
// - deselected: standby, inputs ignored, output floating
// - serial clock edges count only while selected
// - first byte after select fall is command
// - output driven only while returning read data
// - protect flag and low pin block status write
// - hold low freezes operation, ignores clock, select
// - three address bytes, upper six bits ignored
// - 262144 byte locations, bits moved serially
// - memory write finishes within the byte itself
// - nine eight-bit commands are recognised
// - clock level at select fall picks mode
// - unknown command: ignore input until next select
// - writes disabled at power-up, latch needed first
`ifndef SPI_FRAM_REGS_SVH
`define SPI_FRAM_REGS_SVH

// command opcodes
`define SET_WRITE_LATCH_CMD   8'h06
`define CLEAR_WRITE_LATCH_CMD 8'h04
`define STATUS_READ_CMD       8'h05
`define STATUS_WRITE_CMD      8'h01
`define MEM_READ_CMD          8'h03
`define FAST_READ_CMD         8'h0B
`define MEM_WRITE_CMD         8'h02
`define SLEEP_CMD             8'hB9
`define ID_READ_CMD           8'h9F

// status byte field positions
`define ST_PROTECT_BIT 7
`define ST_BLOCK_HI    3
`define ST_BLOCK_LO    2
`define ST_LATCH_BIT   1
`define ST_WRITE_MASK  8'h8C

// protocol counts
`define ADDR_BITS      18
`define LAST_BIT       3'h7
`define LAST_ADDR_BYTE 2'h2
`define LAST_ID_BYTE   2'h3
// identity bytes: arbitrary neutral value
`define ID_WORD        32'h00A5_5A01

`endif

// *** rtl/spi_fram_slave_port.sv ***
// serial slave port of a byte-wide nonvolatile memory
`timescale 1ns/1ps
`include "spi_fram_regs.svh"
module spi_fram_slave_port
    import spi_fram_pkg::*;
#(
    parameter int ADDR_W = `ADDR_BITS
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    output logic      so,
    output logic      so_oe,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      standby,
    output logic      spi_mode3,
    output logic      protect_enable_flag,
    output logic      write_latch
);
    // two-stage synchronisers; logic reads stage two and the sck_d delay stage
    logic sck_s1, sck_s2, sck_d;
    logic cs_s1, cs_s2;
    logic si_s1, si_s2;
    logic hold_s1, hold_s2;
    logic wp_s1, wp_s2;

    // protocol state
    phase_t            state,    next_state;
    logic              sel,      next_sel;      // selected, frozen by hold
    logic              mode3,    next_mode3;
    logic [2:0]        bit_cnt,  next_bit_cnt;
    logic [1:0]        byte_cnt, next_byte_cnt;
    logic [6:0]        shift,    next_shift;
    logic [ADDR_W-1:0] addr,     next_addr;
    logic              is_write, next_is_write;
    logic              is_fast,  next_is_fast;
    logic              latch,    next_latch;
    logic              wrote,    next_wrote;   // a write consumed the latch
    logic [7:0]        stat,     next_stat;    // stored status bits only
    logic              so_data,  next_so_data;
    logic              drive,    next_drive;

    // edge events seen on the fast clock
    logic       rise, fall, cs_fall, desel, byte_done;
    logic [7:0] shift_in, status_byte, out_byte, id_byte;
    logic [7:0] mem_rdata;
    logic       mem_we;
    logic [31:0] id_word;

    // input synchronisers, constants under reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sck_s1  <= 1'b0;
            sck_s2  <= 1'b0;
            sck_d   <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            si_s1   <= 1'b0;
            si_s2   <= 1'b0;
            hold_s1 <= 1'b1;
            hold_s2 <= 1'b1;
            wp_s1   <= 1'b1;
            wp_s2   <= 1'b1;
        end else begin
            sck_s1  <= sck;
            sck_s2  <= sck_s1;
            sck_d   <= sck_s2;
            cs_s1   <= cs_n;
            cs_s2   <= cs_s1;
            si_s1   <= si;
            si_s2   <= si_s1;
            hold_s1 <= hold_n;
            hold_s2 <= hold_s1;
            wp_s1   <= wp_n;
            wp_s2   <= wp_s1;
        end
    end

    // edges only matter while selected and not held; the port is fully
    // edge driven so a stopped clock simply leaves every register as is
    assign rise      = sel & hold_s2 & ~cs_s2 & sck_s2 & ~sck_d;
    assign fall      = sel & hold_s2 & ~cs_s2 & ~sck_s2 & sck_d;
    assign cs_fall   = hold_s2 & ~sel & ~cs_s2;
    assign desel     = hold_s2 & sel & cs_s2;
    assign byte_done = (bit_cnt == `LAST_BIT);
    assign shift_in  = {shift, si_s2};

    // status byte as read back, latch shown live
    always_comb begin
        status_byte = stat & `ST_WRITE_MASK;
        status_byte[`ST_LATCH_BIT] = latch;
    end

    // identity bytes, first byte from the top
    assign id_word = `ID_WORD;
    always_comb begin
        id_byte = id_word[31:24];
        case (byte_cnt)
            2'h1: id_byte = id_word[23:16];
            2'h2: id_byte = id_word[15:8];
            2'h3: id_byte = id_word[7:0];
            default: id_byte = id_word[31:24];
        endcase
    end

    // byte source for the read phases
    always_comb begin
        out_byte = mem_rdata;
        if (state == ST_SREAD) begin
            out_byte = status_byte;
        end else if (state == ST_IDRD) begin
            out_byte = id_byte;
        end
    end

    // write happens on the last rising edge of the data byte
    assign mem_we = rise & byte_done & (state == ST_WDATA);

    // byte array, address wraps inside the 18-bit space
    fram_array #(.ADDR_W(ADDR_W), .DATA_W(8)) u_array (
        .clock   (clock),
        .rd_addr (addr),
        .rd_data (mem_rdata),
        .we      (mem_we),
        .wr_addr (addr),
        .wr_data (shift_in)
    );

    // next values of the protocol state
    always_comb begin
        next_state    = state;
        next_sel      = sel;
        next_mode3    = mode3;
        next_bit_cnt  = bit_cnt;
        next_byte_cnt = byte_cnt;
        next_shift    = shift;
        next_addr     = addr;
        next_is_write = is_write;
        next_is_fast  = is_fast;
        next_latch    = latch;
        next_wrote    = wrote;
        next_stat     = stat;
        next_so_data  = so_data;
        next_drive    = drive;
        if (cs_fall) begin
            // fresh frame: command expected, mode from clock level
            next_sel      = 1'b1;
            next_mode3    = sck_s2;
            next_state    = ST_CMD;
            next_bit_cnt  = 3'h0;
            next_byte_cnt = 2'h0;
            next_drive    = 1'b0;
        end else if (desel) begin
            // end of frame: output floats, a used latch is dropped
            next_sel   = 1'b0;
            next_drive = 1'b0;
            next_state = ST_CMD;
            if (wrote) begin
                next_latch = 1'b0;
            end
            next_wrote = 1'b0;
        end else if (rise) begin
            next_shift   = shift_in[6:0];
            next_bit_cnt = bit_cnt + 3'h1;
            if (byte_done) begin
                unique case (state)
                    ST_CMD: begin
                        next_byte_cnt = 2'h0;
                        next_is_write = (shift_in == `MEM_WRITE_CMD);
                        next_is_fast  = (shift_in == `FAST_READ_CMD);
                        case (shift_in)
                            `SET_WRITE_LATCH_CMD: begin
                                next_latch = 1'b1;
                                next_state = ST_IGNORE;
                            end
                            `CLEAR_WRITE_LATCH_CMD: begin
                                next_latch = 1'b0;
                                next_state = ST_IGNORE;
                            end
                            `STATUS_READ_CMD: next_state = ST_SREAD;
                            `STATUS_WRITE_CMD: begin
                                // protect flag plus low pin, or no latch
                                if (latch && !(stat[`ST_PROTECT_BIT] && !wp_s2)) begin
                                    next_state = ST_SWRITE;
                                end else begin
                                    next_state = ST_IGNORE;
                                end
                            end
                            `MEM_READ_CMD,
                            `FAST_READ_CMD,
                            `MEM_WRITE_CMD: next_state = ST_ADDR;
                            `ID_READ_CMD:   next_state = ST_IDRD;
                            // sleep is accepted but has no power effect here
                            `SLEEP_CMD:     next_state = ST_IGNORE;
                            default:        next_state = ST_IGNORE;
                        endcase
                    end
                    ST_ADDR: begin
                        // upper bits fall off the top of the register
                        next_addr     = {addr[ADDR_W-9:0], shift_in};
                        next_byte_cnt = byte_cnt + 2'h1;
                        if (byte_cnt == `LAST_ADDR_BYTE) begin
                            next_byte_cnt = 2'h0;
                            if (is_write) begin
                                next_state = latch ? ST_WDATA : ST_IGNORE;
                            end else begin
                                next_state = is_fast ? ST_DUMMY : ST_RDATA;
                            end
                        end
                    end
                    ST_DUMMY:  next_state = ST_RDATA;
                    ST_RDATA:  next_addr  = addr + 1'b1;
                    ST_WDATA: begin
                        next_addr  = addr + 1'b1;
                        next_wrote = 1'b1;
                    end
                    ST_SREAD:  next_state = ST_SREAD;
                    ST_SWRITE: begin
                        next_stat  = shift_in & `ST_WRITE_MASK;
                        next_wrote = 1'b1;
                        next_state = ST_IGNORE;
                    end
                    ST_IDRD:   next_byte_cnt = byte_cnt + 2'h1;
                    ST_IGNORE: next_state = ST_IGNORE;
                endcase
            end
        end else if (fall) begin
            // bits leave on falling edges, top bit first
            if (state == ST_RDATA || state == ST_SREAD || state == ST_IDRD) begin
                next_so_data = out_byte[~bit_cnt];
                next_drive   = 1'b1;
            end
        end
    end

    // protocol registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_CMD;
            sel      <= 1'b0;
            mode3    <= 1'b0;
            bit_cnt  <= 3'h0;
            byte_cnt <= 2'h0;
            shift    <= 7'h00;
            addr     <= '0;
            is_write <= 1'b0;
            is_fast  <= 1'b0;
            latch    <= 1'b0;
            wrote    <= 1'b0;
            stat     <= 8'h00;
            so_data  <= 1'b0;
            drive    <= 1'b0;
        end else begin
            state    <= next_state;
            sel      <= next_sel;
            mode3    <= next_mode3;
            bit_cnt  <= next_bit_cnt;
            byte_cnt <= next_byte_cnt;
            shift    <= next_shift;
            addr     <= next_addr;
            is_write <= next_is_write;
            is_fast  <= next_is_fast;
            latch    <= next_latch;
            wrote    <= next_wrote;
            stat     <= next_stat;
            so_data  <= next_so_data;
            drive    <= next_drive;
        end
    end

    // output floats whenever hold is low or the part is deselected
    assign so_oe               = drive & sel & hold_s2;
    assign so                  = so_data;
    assign standby             = ~sel;
    assign spi_mode3           = mode3;
    assign protect_enable_flag = stat[`ST_PROTECT_BIT];
    assign write_latch         = latch;

    // checks on the protocol engine
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_status_write_cmd_seen;
        rise && byte_done && state == ST_CMD && shift_in == `STATUS_WRITE_CMD;
    endsequence
    sequence s_protected;
        stat[`ST_PROTECT_BIT] && !wp_s2;
    endsequence

    AST_DESEL_FLOAT: assert property (desel |=> !so_oe [*2])
        else $error("output driven after deselect");
    AST_HOLD_FLOAT: assert property (!hold_s2 |-> !so_oe)
        else $error("output driven while held");
    AST_OUT_ON_FALL: assert property ($changed(so) |-> $past(fall))
        else $error("output moved without a falling edge");
    AST_IN_ON_RISE: assert property ($changed(shift) |-> $past(rise))
        else $error("input shifted without a rising edge");
    AST_HOLD_FREEZE: assert property (!hold_s2 |=> $stable(state) && $stable(bit_cnt)
                                      && $stable(sel))
        else $error("state moved while held");
    AST_WP_BLOCK: assert property (s_status_write_cmd_seen and s_protected |=> state == ST_IGNORE)
        else $error("protected status write accepted");
    AST_CMD_AFTER_FALL: assert property (cs_fall |=> state == ST_CMD && bit_cnt == 3'h0)
        else $error("select fall did not restart command");
    AST_MODE_PICK: assert property (cs_fall |=> spi_mode3 == $past(sck_s2))
        else $error("mode not taken from clock level");
    AST_IGNORE_STAYS: assert property (state == ST_IGNORE && !desel |=> state == ST_IGNORE
                                       && !so_oe)
        else $error("ignored frame woke up");
    AST_WRITE_STEP: assert property (mem_we |=> addr == $past(addr) + 1'b1)
        else $error("address did not step after write");
    AST_LATCH_NEEDED: assert property (mem_we |-> write_latch)
        else $error("memory written without latch");
endmodule // spi_fram_slave_port

// *** sim/spi_fram_slave_port_tb.sv ***
// self-checking bench for the serial memory slave port
`timescale 1ns/1ps
`include "spi_fram_regs.svh"
module spi_fram_slave_port_tb;
    logic       clock;               // 50 ns system clock
    logic       resetn;              // async reset, active low
    logic       sck;                 // serial clock from master
    logic       cs_n;                // chip select, active low
    logic       si;                  // data into port
    logic       so;                  // data out of port
    logic       so_oe;               // port drives so
    logic       hold_n;              // hold, active low
    logic       wp_n;                // write protect, active low
    logic       standby;             // deselected flag
    logic       spi_mode3;           // captured clock mode
    logic       protect_enable_flag; // status protect bit
    logic       write_latch;         // write enable latch
    logic [7:0] rx;                  // byte read back
    int         n_fail;              // mismatches
    int         num_checks;          // comparisons made
    int         cycles;              // hang guard
    // free-running system clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    spi_fram_slave_port dut (.clock(clock), .resetn(resetn), .sck(sck), .cs_n(cs_n),
        .si(si), .so(so), .so_oe(so_oe), .hold_n(hold_n), .wp_n(wp_n),
        .standby(standby), .spi_mode3(spi_mode3),
        .protect_enable_flag(protect_enable_flag), .write_latch(write_latch));
    spi_master m (.clock(clock), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
        .si(si), .hold_n(hold_n), .wp_n(wp_n));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one-byte command frame
    task automatic frame(input logic [7:0] op);
        m.sel(1'b0);
        m.xfer(op, rx);
        m.desel();
    endtask
    // opcode plus three address bytes, frame left open
    task automatic open_at(input logic [7:0] op, input logic [23:0] a);
        m.sel(1'b0);
        m.xfer(op, rx);
        for (int i = 2; i >= 0; i--) begin
            m.xfer(a[i*8 +: 8], rx);
        end
    endtask
    // latch, then status write
    task automatic status_write_cmd(input logic [7:0] v);
        frame(`SET_WRITE_LATCH_CMD);
        m.sel(1'b0);
        m.xfer(`STATUS_WRITE_CMD, rx);
        m.xfer(v, rx);
        m.desel();
    endtask
    // reset state, then clocking with select high must do nothing
    task automatic t_reset_idle();
        check(standby, 8'h01);
        check(so_oe, 8'h00);
        check(write_latch, 8'h00);
        m.xfer(`SET_WRITE_LATCH_CMD, rx);
        m.desel();
        check(write_latch, 8'h00);
        check(so_oe, 8'h00);
    endtask
    // latched write of two bytes, high address bits junk, then unlatched write
    task automatic t_write();
        frame(`SET_WRITE_LATCH_CMD);
        check(write_latch, 8'h01);
        open_at(`MEM_WRITE_CMD, 24'hFC0010);
        m.xfer(8'hA5, rx);
        m.xfer(8'h3C, rx);
        m.desel();
        check(write_latch, 8'h00);
        open_at(`MEM_WRITE_CMD, 24'h000011);
        m.xfer(8'h77, rx);
        m.desel();
    endtask
    // read back with hold between bytes; toggles in hold must not shift
    task automatic t_read();
        open_at(`MEM_READ_CMD, 24'h000010);
        m.xfer(8'h00, rx);
        check(rx, 8'hA5);
        check(so_oe, 8'h01);
        m.pause();
        check(so_oe, 8'h00);
        m.resume();
        check(so_oe, 8'h01);
        m.xfer(8'h00, rx);
        check(rx, 8'h3C);
        m.desel();
        check(so_oe, 8'h00);
        check(standby, 8'h01);
        open_at(`FAST_READ_CMD, 24'h000011);
        m.xfer(8'h00, rx);
        m.xfer(8'h00, rx);
        check(rx, 8'h3C);
        m.desel();
    endtask
    // protect flag with the pin low refuses status write
    task automatic t_status();
        status_write_cmd(8'h80);
        check(protect_enable_flag, 8'h01);
        m.sel(1'b0);
        m.xfer(`STATUS_READ_CMD, rx);
        m.xfer(8'h00, rx);
        check(rx, 8'h80);
        m.desel();
        m.set_wp(1'b0);
        status_write_cmd(8'h00);
        check(protect_enable_flag, 8'h01);
        m.set_wp(1'b1);
        status_write_cmd(8'h00);
        check(protect_enable_flag, 8'h00);
        // only protect and block bits stick; latch reads back cleared
        status_write_cmd(8'hFF);
        m.sel(1'b0);
        m.xfer(`STATUS_READ_CMD, rx);
        m.xfer(8'h00, rx);
        check(rx, 8'h8C);
        m.desel();
        status_write_cmd(8'h00);
        check(protect_enable_flag, 8'h00);
    endtask
    // unknown opcode kills the frame; later bytes are not commands
    task automatic t_junk();
        m.sel(1'b0);
        m.xfer(8'hFF, rx);
        m.xfer(`SET_WRITE_LATCH_CMD, rx);
        m.xfer(`STATUS_READ_CMD, rx);
        check(so_oe, 8'h00);
        m.desel();
        check(write_latch, 8'h00);
        frame(`SET_WRITE_LATCH_CMD);
        frame(`CLEAR_WRITE_LATCH_CMD);
        check(write_latch, 8'h00);
        frame(`SLEEP_CMD);
        m.sel(1'b0);
        m.xfer(`ID_READ_CMD, rx);
        for (int k = 0; k < 4; k++) begin
            m.xfer(8'h00, rx);
            check(rx, 8'(`ID_WORD >> (24 - 8 * k)));
        end
        m.desel();
    endtask
    // clock high at select fall means mode 3; status still readable
    task automatic t_mode3();
        m.sel(1'b1);
        check(spi_mode3, 8'h01);
        m.xfer(`STATUS_READ_CMD, rx);
        m.xfer(8'h00, rx);
        check(rx, 8'h00);
        m.desel();
        m.sel(1'b0);
        check(spi_mode3, 8'h00);
        m.desel();
    endtask
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            close_out();
        end
    end
    // reset, then the scenarios in order
    initial begin
        resetn = 1'b0;
        m.park();
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset_idle();
        t_write();
        t_read();
        t_status();
        t_junk();
        t_mode3();
        close_out();
    end
endmodule // spi_fram_slave_port_tb

// *** sim/spi_master.sv ***
// serial bus master model driving the memory port pins
`timescale 1ns/1ps
module spi_master (
    input  wire logic clock,
    input  wire logic so,
    input  wire logic so_oe,
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    output logic      wp_n
);
    logic idle_hi; // clock idle level, 1 in mode 3
    logic miso;    // line as seen; undriven line shows the inverse, never a stale bit
    assign miso = so_oe ? so : ~so;
    // pins idle: deselected, hold and protect released; the bench calls this
    // at time zero so every pin level comes from one stimulus source
    task automatic park();
        idle_hi = 1'b0;
        sck <= idle_hi;
        cs_n <= 1'b1;
        si <= 1'b0;
        hold_n <= 1'b1;
        wp_n <= 1'b1;
    endtask
    // wait whole system clocks; every pin change after park lands on a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // park clock at idle level, then a fresh select fall before the opcode
    task automatic sel(input logic mode3);
        idle_hi = mode3;
        sck <= mode3;
        tick(4);
        cs_n <= 1'b0;
        tick(4);
    endtask
    // one byte: data set while clock low, read back late in the high phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b0;
            si <= tx[i];
            tick(4);
            sck <= 1'b1;
            tick(4);
            rx[i] = miso;
        end
    endtask
    // end of frame; data line scrambled once released
    task automatic desel();
        tick(4);
        cs_n <= 1'b1;
        tick(4);
        sck <= idle_hi;
        si <= ~si;
        tick(8);
    endtask
    // hold taken with clock low; clock toggles meanwhile and must be ignored
    task automatic pause();
        sck <= 1'b0;
        tick(4);
        hold_n <= 1'b0;
        tick(4);
        repeat (3) begin
            sck <= 1'b1;
            si <= ~si;
            tick(4);
            sck <= 1'b0;
            tick(4);
        end
    endtask
    // hold released, clock still low
    task automatic resume();
        hold_n <= 1'b1;
        tick(4);
    endtask
    // protect pin level, changed between frames only
    task automatic set_wp(input logic b);
        wp_n <= b;
        tick(4);
    endtask
endmodule // spi_master
